// *** verification/iea_exception_unit_asserts.sv ***
// assertion checker for the interrupt entry and atomic unit
`timescale 1ns/10ps
module iea_chk
    import iea_pkg::*;
#(
    parameter int DATA_W = 32
) (
    // clock, reset, issue
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    input wire logic OP_VALID_I,
    input wire iea_pkg::iea_op_t OP_CODE_I,
    // mode and flow
    input wire logic SUPERVISOR_O,
    input wire logic HANDLER_BANK_O,
    input wire logic INT_ENABLE_O,
    input wire logic HANDLER_FETCH_O,
    input wire logic RESUME_O,
    input wire logic ATOMIC_BUSY_O,
    // memory and locks
    input wire logic MEM_ACK_I,
    input wire logic MEM_REQ_O,
    input wire logic MEM_WE_O,
    input wire logic MEM_LOCK_O,
    input wire logic MEM_BYTE_O,
    input wire logic [DATA_W-1:0] MEM_WDATA_O,
    input wire logic TLB_VICTIM_VALID_I,
    input wire logic TLB_EVICT_VALID_O
);
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (RESET_I);
    // phases of an atomic run
    sequence s_go;
        OP_VALID_I && !ATOMIC_BUSY_O && OP_CODE_I inside {IEA_OP_SWAP, IEA_OP_LDSET};
    endsequence
    sequence s_read;
        MEM_REQ_O && !MEM_WE_O && MEM_LOCK_O;
    endsequence
    sequence s_write;
        MEM_REQ_O && MEM_WE_O && MEM_LOCK_O;
    endsequence
    // entry, return and mask
    property p_entry_mode;
        $rose(HANDLER_BANK_O) |-> SUPERVISOR_O && !INT_ENABLE_O;
    endproperty
    a_entry_mode: assert property (p_entry_mode) else $error("entry mode wrong");
    property p_fetch;
        $rose(HANDLER_BANK_O) |-> ##2 HANDLER_FETCH_O;
    endproperty
    a_fetch: assert property (p_fetch) else $error("handler fetch late");
    property p_ret;
        OP_VALID_I && OP_CODE_I == IEA_OP_RETURN && HANDLER_BANK_O |-> ##3 RESUME_O;
    endproperty
    a_ret: assert property (p_ret) else $error("return not in two cycles");
    property p_resume;
        RESUME_O |-> !HANDLER_BANK_O && $past(HANDLER_BANK_O);
    endproperty
    a_resume: assert property (p_resume) else $error("bank not left on resume");
    property p_mask_on;
        OP_VALID_I && OP_CODE_I == IEA_OP_INT_ON && SUPERVISOR_O |=> INT_ENABLE_O;
    endproperty
    a_mask_on: assert property (p_mask_on) else $error("mask not changed");
    // atomic runs and lock answer
    property p_atom_read;
        s_go |=> s_read;
    endproperty
    a_atom_read: assert property (p_atom_read) else $error("atomic read missing");
    property p_atom_write;
        s_read ##0 MEM_ACK_I |=> s_write;
    endproperty
    a_atom_write: assert property (p_atom_write) else $error("lock lost");
    property p_set_byte;
        s_write ##0 MEM_BYTE_O |-> MEM_WDATA_O[7:0] == IEA_SET_BYTE;
    endproperty
    a_set_byte: assert property (p_set_byte) else $error("set byte not ones");
    property p_no_trap;
        $rose(HANDLER_BANK_O) |-> !$past(ATOMIC_BUSY_O);
    endproperty
    a_no_trap: assert property (p_no_trap) else $error("entry inside atomic");
    property p_tlb_q;
        TLB_VICTIM_VALID_I |=> TLB_EVICT_VALID_O;
    endproperty
    a_tlb_q: assert property (p_tlb_q) else $error("no lock answer");
endmodule

bind iea_exception_unit iea_chk #(.DATA_W(DATA_W)) u_chk (.CORE_CLK_I(CORE_CLK_I),
    .RESET_I(RESET_I), .OP_VALID_I(OP_VALID_I), .OP_CODE_I(OP_CODE_I),
    .SUPERVISOR_O(SUPERVISOR_O), .HANDLER_BANK_O(HANDLER_BANK_O),
    .INT_ENABLE_O(INT_ENABLE_O), .HANDLER_FETCH_O(HANDLER_FETCH_O), .RESUME_O(RESUME_O),
    .ATOMIC_BUSY_O(ATOMIC_BUSY_O), .MEM_ACK_I(MEM_ACK_I), .MEM_REQ_O(MEM_REQ_O),
    .MEM_WE_O(MEM_WE_O), .MEM_LOCK_O(MEM_LOCK_O), .MEM_BYTE_O(MEM_BYTE_O),
    .MEM_WDATA_O(MEM_WDATA_O), .TLB_VICTIM_VALID_I(TLB_VICTIM_VALID_I),
    .TLB_EVICT_VALID_O(TLB_EVICT_VALID_O));

// *** verification/iea_mem_model.sv ***
// external memory model answering each phase after a set latency
`timescale 1ns/10ps
module iea_mem_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // request from the unit
    input wire logic req_i,
    input wire logic we_i,
    input wire logic byte_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] lat_i,
    // answer
    output logic ack_o,
    output logic [31:0] rdata_o
);
    logic [31:0] mem_ff [16];
    logic [31:0] rd_ff;
    logic [3:0] cnt_ff;
    logic [3:0] idx;
    // data valid only with the ack, inverted otherwise
    assign idx = addr_i[5:2];
    assign rdata_o = ack_o ? rd_ff : ~rd_ff;
    // one ack per phase; no other requester, so the run stays whole
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            cnt_ff <= 4'h0;
            rd_ff <= 32'h0;
            for (int i = 0; i < 16; i++) begin
                mem_ff[i] <= 32'h5a5a0000 + 32'(i);
            end
        end else if (req_i && !ack_o && cnt_ff == lat_i) begin
            ack_o <= 1'b1;
            cnt_ff <= 4'h0;
            rd_ff <= mem_ff[idx];
            if (we_i && byte_i) begin
                mem_ff[idx][7:0] <= wdata_i[7:0];
            end else if (we_i) begin
                mem_ff[idx] <= wdata_i;
            end
        end else begin
            ack_o <= 1'b0;
            cnt_ff <= (req_i && !ack_o) ? cnt_ff + 4'h1 : 4'h0;
        end
    end
endmodule

// *** verification/tb.sv ***
// self-checking bench for the interrupt entry and atomic unit
`timescale 1ns/10ps
module tb;
    import iea_pkg::*;
    logic clk = 1'b0, rst = 1'b1, irq = 1'b0, opv = 1'b0, fdone = 1'b0, bwe = 1'b0;
    logic lwe = 1'b0, lval = 1'b0, vv = 1'b0;
    iea_op_t opc = IEA_OP_NONE;
    logic [31:0] opa = 32'h0, opr = 32'h0, pc = 32'h0, bwd = 32'h0;
    logic [2:0] bwa = 3'h0, bra = 3'h0;
    logic [5:0] lidx = 6'h0, vidx = 6'h0;
    logic [3:0] lat = 4'h0;
    logic mreq, mwe, mbyte, mack;
    logic [31:0] maddr, mwd, mrd;
    int num_errors = 0;
    int num_checks = 0;
    // clock at 125 MHz
    initial forever #4 clk = ~clk;
    iea_exception_unit dut (.CORE_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(1'b1), .IRQ_REQ_I(irq),
        .OP_VALID_I(opv), .OP_CODE_I(opc), .OP_ADDR_I(opa), .OP_REG_I(opr), .CUR_PC_I(pc),
        .CUR_NPC_I(pc + 32'h4), .FIRST_DONE_I(fdone), .BANK_WE_I(bwe), .BANK_WADDR_I(bwa),
        .BANK_WDATA_I(bwd), .BANK_RADDR_I(bra), .BANK_RDATA_O(), .SUPERVISOR_O(),
        .HANDLER_BANK_O(), .INT_ENABLE_O(), .HANDLER_FETCH_O(), .ENTRY_DONE_O(),
        .ENTRY_LATE_O(), .RESUME_O(), .RESUME_PC_O(), .RESUME_NPC_O(), .ATOMIC_BUSY_O(),
        .ATOMIC_DONE_O(), .ATOMIC_RDATA_O(), .MEM_ACK_I(mack), .MEM_RDATA_I(mrd),
        .MEM_REQ_O(mreq), .MEM_WE_O(mwe), .MEM_LOCK_O(), .MEM_BYTE_O(mbyte),
        .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwd), .TLB_LOCK_WE_I(lwe), .TLB_LOCK_IDX_I(lidx[3:0]),
        .TLB_LOCK_VAL_I(lval), .TLB_VICTIM_VALID_I(vv), .TLB_VICTIM_IDX_I(vidx[3:0]),
        .TLB_EVICT_VALID_O(), .TLB_EVICT_OK_O(), .CACHE_LOCK_WE_I(lwe),
        .CACHE_LOCK_IDX_I(lidx), .CACHE_LOCK_VAL_I(lval), .CACHE_VICTIM_VALID_I(vv),
        .CACHE_VICTIM_IDX_I(vidx), .CACHE_EVICT_VALID_O(), .CACHE_EVICT_OK_O());
    iea_mem_model u_mem (.clk_i(clk), .rst_i(rst), .req_i(mreq), .we_i(mwe), .byte_i(mbyte),
        .addr_i(maddr), .wdata_i(mwd), .lat_i(lat), .ack_o(mack), .rdata_o(mrd));
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // one-cycle op strobe, entered at a falling edge
    task automatic op(input iea_op_t c, input logic [31:0] a, input logic [31:0] r);
        opc = c;
        opa = a;
        opr = r;
        opv = 1'b1;
        @(negedge clk);
        opv = 1'b0;
    endtask
    task automatic rd_bank(input logic [2:0] a, input logic [31:0] exp);
        bra = a;
        @(negedge clk);
        chk(dut.BANK_RDATA_O, exp);
    endtask
    // entry, bank use, optional late flag, then return
    task automatic t_entry(input logic late);
        int n;
        n = 0;
        pc = 32'h00004a10 + {late, 4'h0};
        irq = 1'b1;
        while (dut.HANDLER_BANK_O !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        irq = 1'b0;
        chk(dut.SUPERVISOR_O, 1'b1);
        chk(dut.INT_ENABLE_O, 1'b0);
        repeat (2) @(negedge clk);
        chk(dut.HANDLER_FETCH_O, 1'b1);
        if (late) begin
            repeat (14) @(negedge clk);
            chk(dut.ENTRY_LATE_O, 1'b1);
        end else begin
            fdone = 1'b1;
            @(negedge clk);
            fdone = 1'b0;
            chk(dut.ENTRY_DONE_O, 1'b1);
            chk(dut.ENTRY_LATE_O, 1'b0);
        end
        rd_bank(3'h0, pc);
        rd_bank(3'h1, pc + 32'h4);
        bwe = 1'b1;
        bwa = 3'h2;
        bwd = 32'hc0de0002;
        @(negedge clk);
        bwe = 1'b0;
        rd_bank(3'h2, 32'hc0de0002);
        op(IEA_OP_RETURN, 32'h0, 32'h0);
        n = 0;
        while (dut.RESUME_O !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        chk(32'(n), 32'(IEA_RESTORE_CLK));
        chk(dut.RESUME_PC_O, pc);
        chk(dut.RESUME_NPC_O, pc + 32'h4);
        chk(dut.HANDLER_BANK_O, 1'b0);
        chk(dut.INT_ENABLE_O, 1'b1);
    endtask
    // atomic op with optional interrupt raised while it runs
    task automatic t_atom(input iea_op_t c, input logic [31:0] a, input logic [31:0] r,
                          input logic [31:0] exp, input logic irq_mid);
        int n;
        n = 0;
        op(c, a, r);
        irq = irq_mid;
        while (dut.ATOMIC_DONE_O !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        chk(dut.ATOMIC_RDATA_O, exp);
        chk(dut.HANDLER_BANK_O, 1'b0);
        @(negedge clk); // busy falls one cycle after done
    endtask
    // lock an entry, then query it and its neighbour
    task automatic t_lock;
        lwe = 1'b1;
        lval = 1'b1;
        lidx = 6'h5;
        @(negedge clk);
        lwe = 1'b0;
        vv = 1'b1;
        vidx = 6'h5;
        @(negedge clk);
        chk(dut.TLB_EVICT_OK_O, 1'b0);
        chk(dut.CACHE_EVICT_OK_O, 1'b0);
        chk(dut.CACHE_EVICT_VALID_O, 1'b1);
        vidx = 6'h6;
        @(negedge clk);
        chk(dut.TLB_EVICT_OK_O, 1'b1);
        chk(dut.CACHE_EVICT_OK_O, 1'b1);
        vv = 1'b0;
    endtask
    // main sequence
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        op(IEA_OP_INT_ON, 32'h0, 32'h0);
        chk(dut.INT_ENABLE_O, 1'b1);
        op(IEA_OP_INT_OFF, 32'h0, 32'h0);
        chk(dut.INT_ENABLE_O, 1'b0);
        op(IEA_OP_INT_ON, 32'h0, 32'h0);
        chk(dut.INT_ENABLE_O, 1'b1);
        t_atom(IEA_OP_SWAP, 32'h8, 32'h12345678, 32'h5a5a0002, 1'b0);
        t_atom(IEA_OP_SWAP, 32'h8, 32'h0, 32'h12345678, 1'b0);
        t_atom(IEA_OP_LDSET, 32'hc, 32'h0, 32'h00000003, 1'b0);
        t_atom(IEA_OP_LDSET, 32'hc, 32'h0, 32'h000000ff, 1'b0);
        lat = 4'h5;
        t_atom(IEA_OP_SWAP, 32'h10, 32'ha5, 32'h5a5a0004, 1'b1);
        t_entry(1'b0);
        t_entry(1'b1);
        t_lock();
        final_report();
    end
    // watchdog: the run needs about a hundred cycles
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        final_report();
    end
endmodule

// *** verilog/iea_atomic_seq.sv ***
// read then write memory sequence with the location held locked
`timescale 1ns/10ps
module iea_atomic_seq
    import iea_pkg::*;
#(
    parameter int DATA_W = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    // command
    input wire logic start_i,
    input wire logic byte_i,
    input wire logic [DATA_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic busy_o,
    output logic done_o,
    output logic [DATA_W-1:0] rdata_o,
    // memory side
    input wire logic mem_ack_i,
    input wire logic [DATA_W-1:0] mem_rdata_i,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic mem_lock_o,
    output logic mem_byte_o,
    output logic [DATA_W-1:0] mem_addr_o,
    output logic [DATA_W-1:0] mem_wdata_o
);

    // ********
    // sequence state
    // ********
    iea_at_state_t state_ff;
    logic [DATA_W-1:0] set_word;
    logic [DATA_W-1:0] rd_value;

    assign set_word = {{(DATA_W-IEA_BYTE_W){1'b0}}, IEA_SET_BYTE};
    assign rd_value = mem_byte_o ? {{(DATA_W-IEA_BYTE_W){1'b0}}, mem_rdata_i[IEA_BYTE_W-1:0]}
                                 : mem_rdata_i; // op strobe is gone by now

    // read phase, write phase, one done cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= IEA_AT_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= '0;
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_lock_o <= 1'b0;
            mem_byte_o <= 1'b0;
            mem_addr_o <= '0;
            mem_wdata_o <= '0;
        end else if (en_i) begin
            done_o <= 1'b0;
            case (state_ff)
                IEA_AT_IDLE: begin
                    if (start_i) begin
                        state_ff <= IEA_AT_READ;
                        busy_o <= 1'b1;
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b0;
                        mem_lock_o <= 1'b1;
                        mem_byte_o <= byte_i;
                        mem_addr_o <= addr_i;
                        mem_wdata_o <= byte_i ? set_word : wdata_i;
                    end
                end
                IEA_AT_READ: begin
                    if (mem_ack_i) begin
                        state_ff <= IEA_AT_WRITE;
                        rdata_o <= rd_value;
                        mem_we_o <= 1'b1;
                    end
                end
                IEA_AT_WRITE: begin
                    if (mem_ack_i) begin
                        state_ff <= IEA_AT_DONE;
                        mem_req_o <= 1'b0;
                        mem_we_o <= 1'b0;
                        mem_lock_o <= 1'b0;
                        done_o <= 1'b1;
                    end
                end
                default: begin
                    state_ff <= IEA_AT_IDLE;
                    busy_o <= 1'b0;
                end
            endcase
        end
    end

endmodule

// *** verilog/iea_exception_unit.sv ***
// interrupt entry, return, mask guard, atomic memory ops and lock tables
`timescale 1ns/10ps
module iea_exception_unit #(
    parameter int DATA_W = 32,
    parameter int TLB_ENTRIES = 16,
    parameter int TLB_IDX_W = 4,
    parameter int CACHE_LINES = 64,
    parameter int CACHE_IDX_W = 6
) (
    // clock, reset, enable
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    input wire logic CLK_EN_I,
    // asynchronous interrupt request pin
    input wire logic IRQ_REQ_I,
    // operation issue from the pipeline
    input wire logic OP_VALID_I,
    input wire iea_pkg::iea_op_t OP_CODE_I,
    input wire logic [DATA_W-1:0] OP_ADDR_I,
    input wire logic [DATA_W-1:0] OP_REG_I,
    input wire logic [DATA_W-1:0] CUR_PC_I,
    input wire logic [DATA_W-1:0] CUR_NPC_I,
    input wire logic FIRST_DONE_I,
    // handler bank access
    input wire logic BANK_WE_I,
    input wire logic [iea_pkg::IEA_BANK_AW-1:0] BANK_WADDR_I,
    input wire logic [DATA_W-1:0] BANK_WDATA_I,
    input wire logic [iea_pkg::IEA_BANK_AW-1:0] BANK_RADDR_I,
    output logic [DATA_W-1:0] BANK_RDATA_O,
    // mode and flow status
    output logic SUPERVISOR_O,
    output logic HANDLER_BANK_O,
    output logic INT_ENABLE_O,
    output logic HANDLER_FETCH_O,
    output logic ENTRY_DONE_O,
    output logic ENTRY_LATE_O,
    output logic RESUME_O,
    output logic [DATA_W-1:0] RESUME_PC_O,
    output logic [DATA_W-1:0] RESUME_NPC_O,
    // atomic result
    output logic ATOMIC_BUSY_O,
    output logic ATOMIC_DONE_O,
    output logic [DATA_W-1:0] ATOMIC_RDATA_O,
    // external memory
    input wire logic MEM_ACK_I,
    input wire logic [DATA_W-1:0] MEM_RDATA_I,
    output logic MEM_REQ_O,
    output logic MEM_WE_O,
    output logic MEM_LOCK_O,
    output logic MEM_BYTE_O,
    output logic [DATA_W-1:0] MEM_ADDR_O,
    output logic [DATA_W-1:0] MEM_WDATA_O,
    // translation buffer locks
    input wire logic TLB_LOCK_WE_I,
    input wire logic [TLB_IDX_W-1:0] TLB_LOCK_IDX_I,
    input wire logic TLB_LOCK_VAL_I,
    input wire logic TLB_VICTIM_VALID_I,
    input wire logic [TLB_IDX_W-1:0] TLB_VICTIM_IDX_I,
    output logic TLB_EVICT_VALID_O,
    output logic TLB_EVICT_OK_O,
    // cache locks
    input wire logic CACHE_LOCK_WE_I,
    input wire logic [CACHE_IDX_W-1:0] CACHE_LOCK_IDX_I,
    input wire logic CACHE_LOCK_VAL_I,
    input wire logic CACHE_VICTIM_VALID_I,
    input wire logic [CACHE_IDX_W-1:0] CACHE_VICTIM_IDX_I,
    output logic CACHE_EVICT_VALID_O,
    output logic CACHE_EVICT_OK_O
);
    import iea_pkg::*;

    // ********
    // elaboration checks
    // ********
    if (DATA_W < IEA_BYTE_W) begin : g_bad_width
        $error("iea_exception_unit: DATA_W too small");
    end

    // ********
    // state and storage
    // ********
    iea_state_t state_ff;
    logic [DATA_W-1:0] bank_ff [IEA_BANK_REGS];
    logic irq_meta_ff;
    logic irq_sync_ff;
    logic prev_super_ff;
    logic prev_int_en_ff;
    logic [IEA_ENTRY_CNT_W-1:0] entry_cnt_ff;
    logic entry_open_ff;
    logic atomic_busy;
    logic atomic_done;

    // ********
    // decode
    // ********
    wire op_int_on = OP_VALID_I && (OP_CODE_I == IEA_OP_INT_ON);
    wire op_int_off = OP_VALID_I && (OP_CODE_I == IEA_OP_INT_OFF);
    wire op_return = OP_VALID_I && (OP_CODE_I == IEA_OP_RETURN);
    wire op_swap = OP_VALID_I && (OP_CODE_I == IEA_OP_SWAP);
    wire op_ldset = OP_VALID_I && (OP_CODE_I == IEA_OP_LDSET);
    wire atomic_start = (op_swap || op_ldset) && !atomic_busy;
    wire mask_write = (op_int_on || op_int_off) && SUPERVISOR_O;
    wire irq_accept = irq_sync_ff && INT_ENABLE_O && (state_ff == IEA_ST_IDLE)
                      && !atomic_busy && !atomic_start;
    wire ret_accept = op_return && SUPERVISOR_O && (state_ff == IEA_ST_HANDLER);
    wire sw_bank_we = BANK_WE_I && HANDLER_BANK_O
                      && (state_ff != IEA_ST_SAVE) && (state_ff != IEA_ST_VECTOR);
    wire entry_hit = entry_open_ff && FIRST_DONE_I && (state_ff == IEA_ST_HANDLER);
    wire entry_over = entry_open_ff && !FIRST_DONE_I && (entry_cnt_ff >= IEA_ENTRY_LIMIT);

    // ********
    // interrupt pin synchroniser
    // ********
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            irq_meta_ff <= 1'b0;
            irq_sync_ff <= 1'b0;
        end else if (CLK_EN_I) begin
            irq_meta_ff <= IRQ_REQ_I;
            irq_sync_ff <= irq_meta_ff;
        end
    end

    // ********
    // entry and return sequence
    // ********
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_ff <= IEA_ST_IDLE;
            HANDLER_FETCH_O <= 1'b0;
            RESUME_O <= 1'b0;
        end else if (CLK_EN_I) begin
            HANDLER_FETCH_O <= 1'b0;
            RESUME_O <= 1'b0;
            case (state_ff)
                IEA_ST_IDLE: begin
                    if (irq_accept) begin
                        state_ff <= IEA_ST_SAVE;
                    end
                end
                IEA_ST_SAVE: begin
                    state_ff <= IEA_ST_VECTOR;
                end
                IEA_ST_VECTOR: begin
                    state_ff <= IEA_ST_HANDLER;
                    HANDLER_FETCH_O <= 1'b1;
                end
                IEA_ST_HANDLER: begin
                    if (ret_accept) begin
                        state_ff <= IEA_ST_REST1;
                    end
                end
                IEA_ST_REST1: begin
                    state_ff <= IEA_ST_REST2;
                end
                default: begin
                    state_ff <= IEA_ST_IDLE;
                    RESUME_O <= 1'b1;
                end
            endcase
        end
    end

    // ********
    // mode, bank select and mask
    // ********
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            SUPERVISOR_O <= 1'b1;
            HANDLER_BANK_O <= 1'b0;
            INT_ENABLE_O <= 1'b0;
            prev_super_ff <= 1'b1;
            prev_int_en_ff <= 1'b0;
        end else if (CLK_EN_I) begin
            if (irq_accept) begin
                prev_super_ff <= SUPERVISOR_O;
                prev_int_en_ff <= INT_ENABLE_O;
                SUPERVISOR_O <= 1'b1;
                HANDLER_BANK_O <= 1'b1;
                INT_ENABLE_O <= 1'b0;
            end else if (state_ff == IEA_ST_REST2) begin
                SUPERVISOR_O <= prev_super_ff;
                HANDLER_BANK_O <= 1'b0;
                INT_ENABLE_O <= prev_int_en_ff;
            end else if (mask_write) begin
                INT_ENABLE_O <= op_int_on;
            end
        end
    end

    // ********
    // handler bank, hardware save wins
    // ********
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            for (int i = 0; i < IEA_BANK_REGS; i++) begin
                bank_ff[i] <= '0;
            end
        end else if (CLK_EN_I) begin
            if (irq_accept) begin
                bank_ff[IEA_BANK_PC_IDX] <= CUR_PC_I;
                bank_ff[IEA_BANK_NPC_IDX] <= CUR_NPC_I;
            end else if (sw_bank_we) begin
                bank_ff[BANK_WADDR_I] <= BANK_WDATA_I;
            end
        end
    end

    // bank read port and restored counters
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            BANK_RDATA_O <= '0;
            RESUME_PC_O <= '0;
            RESUME_NPC_O <= '0;
        end else if (CLK_EN_I) begin
            BANK_RDATA_O <= bank_ff[BANK_RADDR_I];
            if (state_ff == IEA_ST_REST1) begin
                RESUME_PC_O <= bank_ff[IEA_BANK_PC_IDX];
            end
            if (state_ff == IEA_ST_REST2) begin
                RESUME_NPC_O <= bank_ff[IEA_BANK_NPC_IDX];
            end
        end
    end

    // ********
    // entry latency watch
    // ********
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            entry_cnt_ff <= '0;
            entry_open_ff <= 1'b0;
            ENTRY_DONE_O <= 1'b0;
            ENTRY_LATE_O <= 1'b0;
        end else if (CLK_EN_I) begin
            ENTRY_DONE_O <= entry_hit;
            if (irq_accept) begin
                entry_cnt_ff <= IEA_ENTRY_START;
                entry_open_ff <= 1'b1;
                ENTRY_LATE_O <= 1'b0;
            end else if (entry_hit) begin
                entry_open_ff <= 1'b0;
            end else if (entry_over) begin
                entry_open_ff <= 1'b0;
                ENTRY_LATE_O <= 1'b1;
            end else if (entry_open_ff) begin
                entry_cnt_ff <= entry_cnt_ff + 4'h1;
            end
        end
    end

    // ********
    // atomic memory ops
    // ********
    iea_atomic_seq #(.DATA_W(DATA_W)) u_atomic (
        .clk_i(CORE_CLK_I),
        .rst_i(RESET_I),
        .en_i(CLK_EN_I),
        .start_i(atomic_start),
        .byte_i(op_ldset),
        .addr_i(OP_ADDR_I),
        .wdata_i(OP_REG_I),
        .busy_o(atomic_busy),
        .done_o(atomic_done),
        .rdata_o(ATOMIC_RDATA_O),
        .mem_ack_i(MEM_ACK_I),
        .mem_rdata_i(MEM_RDATA_I),
        .mem_req_o(MEM_REQ_O),
        .mem_we_o(MEM_WE_O),
        .mem_lock_o(MEM_LOCK_O),
        .mem_byte_o(MEM_BYTE_O),
        .mem_addr_o(MEM_ADDR_O),
        .mem_wdata_o(MEM_WDATA_O)
    );

    assign ATOMIC_BUSY_O = atomic_busy;
    assign ATOMIC_DONE_O = atomic_done;

    // ********
    // translation and cache lock tables
    // ********
    iea_lock_table #(.ENTRIES(TLB_ENTRIES), .IDX_W(TLB_IDX_W)) u_tlb_lock (
        .clk_i(CORE_CLK_I),
        .rst_i(RESET_I),
        .en_i(CLK_EN_I),
        .lock_we_i(TLB_LOCK_WE_I),
        .lock_idx_i(TLB_LOCK_IDX_I),
        .lock_val_i(TLB_LOCK_VAL_I),
        .unlock_all_i(1'b0),
        .victim_valid_i(TLB_VICTIM_VALID_I),
        .victim_idx_i(TLB_VICTIM_IDX_I),
        .evict_valid_o(TLB_EVICT_VALID_O),
        .evict_ok_o(TLB_EVICT_OK_O)
    );

    iea_lock_table #(.ENTRIES(CACHE_LINES), .IDX_W(CACHE_IDX_W)) u_cache_lock (
        .clk_i(CORE_CLK_I),
        .rst_i(RESET_I),
        .en_i(CLK_EN_I),
        .lock_we_i(CACHE_LOCK_WE_I),
        .lock_idx_i(CACHE_LOCK_IDX_I),
        .lock_val_i(CACHE_LOCK_VAL_I),
        .unlock_all_i(1'b0),
        .victim_valid_i(CACHE_VICTIM_VALID_I),
        .victim_idx_i(CACHE_VICTIM_IDX_I),
        .evict_valid_o(CACHE_EVICT_VALID_O),
        .evict_ok_o(CACHE_EVICT_OK_O)
    );

endmodule

// *** verilog/iea_lock_table.sv ***
// lock bitmap that protects chosen entries from replacement
`timescale 1ns/10ps
module iea_lock_table #(
    parameter int ENTRIES = 16,
    parameter int IDX_W = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    // lock control
    input wire logic lock_we_i,
    input wire logic [IDX_W-1:0] lock_idx_i,
    input wire logic lock_val_i,
    input wire logic unlock_all_i,
    // replacement query
    input wire logic victim_valid_i,
    input wire logic [IDX_W-1:0] victim_idx_i,
    output logic evict_valid_o,
    output logic evict_ok_o
);

    // ********
    // lock bits and answer
    // ********
    logic [ENTRIES-1:0] lock_ff;
    logic victim_locked;

    if (ENTRIES < 2 || (1 << IDX_W) < ENTRIES) begin : g_bad_size
        $error("iea_lock_table: bad ENTRIES or IDX_W");
    end

    assign victim_locked = lock_ff[victim_idx_i];

    // lock bits written by the controller
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lock_ff <= '0;
        end else if (en_i) begin
            if (unlock_all_i) begin
                lock_ff <= '0;
            end else if (lock_we_i) begin
                lock_ff[lock_idx_i] <= lock_val_i;
            end
        end
    end

    // a locked entry is never handed out as a victim
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            evict_valid_o <= 1'b0;
            evict_ok_o <= 1'b0;
        end else if (en_i) begin
            evict_valid_o <= victim_valid_i;
            evict_ok_o <= victim_valid_i & ~victim_locked;
        end
    end

endmodule

// *** verilog/iea_pkg.sv ***
// shared constants and types of the interrupt entry and atomic unit
package iea_pkg;

    // ********
    // data path and handler bank
    // ********
    localparam int IEA_XLEN = 32;
    localparam int IEA_BANK_REGS = 8;
    localparam int IEA_BANK_AW = 3;
    localparam logic [2:0] IEA_BANK_PC_IDX = 3'h0;
    localparam logic [2:0] IEA_BANK_NPC_IDX = 3'h1;

    // ********
    // timing figures, in core clock cycles except the core clock rate in MHz and the entry counter width in bits
    // ********
    localparam int IEA_CORE_CLK_MHZ = 125;
    localparam int IEA_ENTRY_LIMIT_CLK = 14;
    localparam int IEA_RESTORE_CLK = 2;
    localparam int IEA_ENTRY_CNT_W = 4;
    localparam logic [3:0] IEA_ENTRY_LIMIT = 4'(IEA_ENTRY_LIMIT_CLK);
    localparam logic [3:0] IEA_ENTRY_START = 4'h1;

    // ********
    // memory values
    // ********
    localparam logic [7:0] IEA_SET_BYTE = 8'hff;
    localparam int IEA_BYTE_W = 8;

    // ********
    // core operations and states
    // ********
    typedef enum logic [2:0] {
        IEA_OP_NONE = 3'h0,
        IEA_OP_INT_ON = 3'h1,
        IEA_OP_INT_OFF = 3'h2,
        IEA_OP_RETURN = 3'h3,
        IEA_OP_SWAP = 3'h4,
        IEA_OP_LDSET = 3'h5
    } iea_op_t;

    typedef enum logic [2:0] {
        IEA_ST_IDLE = 3'h0,
        IEA_ST_SAVE = 3'h1,
        IEA_ST_VECTOR = 3'h3,
        IEA_ST_HANDLER = 3'h2,
        IEA_ST_REST1 = 3'h6,
        IEA_ST_REST2 = 3'h7
    } iea_state_t;

    typedef enum logic [1:0] {
        IEA_AT_IDLE = 2'h0,
        IEA_AT_READ = 2'h1,
        IEA_AT_WRITE = 2'h3,
        IEA_AT_DONE = 2'h2
    } iea_at_state_t;

endpackage
